//--- logic/adcc_defines.svh
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// Register byte offsets on the APB
`define ADCC_OFF_RES_HIGH     8'h00
`define ADCC_OFF_RES_LOW      8'h04
`define ADCC_OFF_CTRL_PRIMARY 8'h08
`define ADCC_OFF_CFG_SECOND   8'h0C
`define ADCC_OFF_IRQ_STATUS   8'h10
`define ADCC_OFF_IRQ_MASK     8'h14

// Primary control field positions
`define ADCC_CTRL_CLK_HI   7
`define ADCC_CTRL_CLK_LO   6
`define ADCC_CTRL_CHAN_HI  5
`define ADCC_CTRL_CHAN_LO  3
`define ADCC_CTRL_GO       2
`define ADCC_CTRL_POWER    0

// Secondary configuration field positions
`define ADCC_CFG_JUSTIFY   7
`define ADCC_CFG_CLK2      6
`define ADCC_CFG_PORT_HI   3
`define ADCC_CFG_PORT_LO   0

// Interrupt status bit
`define ADCC_IRQ_DONE      0

// Reset values
`define ADCC_CTRL_RESET    8'h00
`define ADCC_CFG_RESET     8'h00
`define ADCC_RES_RESET     10'h000

// Converter geometry
`define ADCC_RES_BITS      10
`define ADCC_CHAN_LARGE    8
`define ADCC_CHAN_SMALL    5

`endif

//--- logic/adcc_pkg.sv
package adcc_pkg;

  // Successive-approximation sequencer states
  typedef enum logic [2:0] {
    ADCC_IDLE = 3'b001,
    ADCC_HOLD = 3'b010,
    ADCC_CONV = 3'b100
  } adcc_state_type;

  typedef logic [9:0] adcc_result_type;

  // Terminal count of the system clock divider for each select code
  function automatic logic [5:0] adcc_div_terminal(input logic [2:0] sel);
    logic [5:0] t;
    t = 6'h00;
    unique case (sel)
      3'b000: t = 6'h01;
      3'b001: t = 6'h07;
      3'b010: t = 6'h1F;
      3'b100: t = 6'h03;
      3'b101: t = 6'h0F;
      3'b110: t = 6'h3F;
      default: t = 6'h00;
    endcase
    return t;
  endfunction

endpackage

//--- logic/adcc_tad_div.sv
`timescale 1ns/10ps
`include "adcc_defines.svh"

module adcc_tad_div (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [2:0] clk_sel,
  input  wire logic       rc_tick,
  output logic            tad_en_q
);
  import adcc_pkg::*;

  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic       use_rc;
  logic       wrap;

  // Codes x11 take the internal RC oscillator tick instead of the divider
  assign use_rc = (clk_sel[1:0] == 2'b11); // [RULE5]
  assign wrap   = (cnt_q >= adcc_div_terminal(clk_sel)); // [RULE5]
  assign cnt_d  = wrap ? 6'h00 : cnt_q + 6'h01;

  // Divider idles while powered down, so counting restarts from zero at each power-up
  always_ff @(posedge sys_clk) begin
    if (!resetn || !run) begin
      cnt_q    <= 6'h00;
      tad_en_q <= 1'b0;
    end else if (use_rc) begin
      cnt_q    <= 6'h00;
      tad_en_q <= rc_tick; // [RULE5]
    end else begin
      cnt_q    <= cnt_d;
      tad_en_q <= wrap; // [RULE5]
    end
  end

  // Fastest divide gives a tick every second cycle, never two in a row
  chk_div2_spacing: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE5]
    (run && clk_sel == 3'b000 && tad_en_q) |=> !tad_en_q)
    else $error("divide-by-two tick repeated");

endmodule

//--- logic/adcc_sar.sv
`timescale 1ns/10ps
`include "adcc_defines.svh"

module adcc_sar (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic        tad_en,
  input  wire logic        comp_in,
  output logic             busy_q,
  output logic             done_q,
  output logic             sample_hold_q,
  output logic [9:0]       dac_code_q,
  output adcc_pkg::adcc_result_type result_q
);
  import adcc_pkg::*;

  adcc_state_type state_q;
  logic [9:0]     trial_q;
  logic [9:0]     keep;

  // Keep the trial bit when the input sits at or above the DAC level
  assign keep = comp_in ? dac_code_q : (dac_code_q & ~trial_q);

  // Hold settles until the next bit tick, then one decision per bit-time
  always_ff @(posedge sys_clk) begin
    done_q <= 1'b0;
    if (!resetn) begin
      result_q <= `ADCC_RES_RESET; // [RULE13]
    end
    if (!resetn || abort) begin
      state_q       <= ADCC_IDLE;
      trial_q       <= 10'h000;
      dac_code_q    <= 10'h000;
      sample_hold_q <= 1'b0;
      busy_q        <= 1'b0;
    end else begin
      unique case (state_q)
        ADCC_IDLE: if (start) begin
          state_q       <= ADCC_HOLD;
          sample_hold_q <= 1'b1;
          busy_q        <= 1'b1;
        end
        ADCC_HOLD: if (tad_en) begin
          state_q    <= ADCC_CONV;
          trial_q    <= 10'h200;
          dac_code_q <= 10'h200;
        end
        ADCC_CONV: if (tad_en) begin
          trial_q    <= trial_q >> 1;
          dac_code_q <= keep | (trial_q >> 1);
          if (trial_q[0]) begin
            result_q      <= keep; // [RULE1]
            done_q        <= 1'b1;
            state_q       <= ADCC_IDLE;
            sample_hold_q <= 1'b0;
            busy_q        <= 1'b0;
          end
        end
      endcase
    end
  end

  // Result register is cleared by reset only, so it survives power-down
  chk_done_single: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE12]
    done_q |=> !done_q && !busy_q)
    else $error("done pulse longer than one cycle");

endmodule

//--- logic/adcc_top.sv
`timescale 1ns/10ps
`include "adcc_defines.svh"

// Function
// [RULE1] Each conversion yields a 10-bit digital result.
// [RULE2] Channel multiplexer serves five inputs on small variant, eight on large.
// [RULE3] Four converter registers: result high, result low, control, configuration.
// [RULE4] Clock select low bits sit at control bits 7-6; third bit in configuration.
// [RULE5] Three-bit select picks system divide 2,8,32,4,16,64 or the RC clock.
// [RULE6] Control bits 5-3 choose analog channel 0 to 7.
// [RULE7] Software never selects a channel the small variant lacks.
// [RULE8] Writing 1 to bit 2 while powered starts; bit reads 1 while busy.
// [RULE9] Hardware clears the trigger bit when the conversion completes.
// [RULE10] Bit 0 powers the converter; cleared, it shuts the converter off.
// [RULE11] Control bit 1 ignores writes and reads 0.
// [RULE12] Completion loads result, clears trigger bit and sets the done flag.
// [RULE13] Reset returns all registers to reset state and aborts conversion.
// [RULE14] Justify bit 1 right-aligns the result, 0 left-aligns it.
// [RULE15] Software waits two bit-times after a conversion before next acquisition.
// [RULE16] Trigger write while unpowered starts nothing and bit stays 0.
// [RULE17] Implemented control bits reset to 0.

module adcc_top #(
  parameter int CHAN_COUNT = `ADCC_CHAN_LARGE
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata_q,
  output logic            pready_q,
  output logic            pslverr_q,
  input  wire logic       comp_in,
  input  wire logic       rc_tick,
  output logic [9:0]      dac_code_q,
  output logic            sample_hold_q,
  output logic [7:0]      chan_enable_q,
  output logic            converter_power_q,
  output logic [3:0]      port_config_q,
  output logic            irq_q
);
  import adcc_pkg::*;

  // Register state
  logic [1:0] clk_sel_low_q;
  logic [2:0] chan_sel_q;
  logic       go_q;
  logic       justify_q;
  logic       clk_sel_bit2_q;
  logic [0:0] irq_stat_q;
  logic [0:0] irq_mask_q;
  logic [7:0] chan_enable_d;

  // Sequencer connections
  logic       tad_en;
  logic       sar_busy;
  logic       sar_done;
  logic [9:0] sar_result;
  logic       start_conv;

  // Bus decode
  logic       access;
  logic       wr_en;
  logic       rd_setup;
  logic       hit_res_high;
  logic       hit_res_low;
  logic       hit_ctrl;
  logic       hit_cfg;
  logic       hit_stat;
  logic       hit_mask;
  logic       mapped;
  logic [7:0] ctrl_view;
  logic [7:0] cfg_view;
  logic [7:0] res_high_view;
  logic [7:0] res_low_view;
  logic [31:0] rd_mux;
  logic [2:0] clk_sel_full;
  logic       go_write;
  logic       done_set;
  logic       power_off_wr;
  logic       sar_abort;
  logic [7:0] ctrl_reset;
  logic [7:0] cfg_reset;

  // APB: answer one cycle into the access phase, three-cycle transfer in all
  assign access       = psel && penable;
  assign wr_en        = access && pwrite && pready_q && !pslverr_q;
  assign rd_setup     = access && !pready_q;
  assign hit_res_high = (paddr == `ADCC_OFF_RES_HIGH);
  assign hit_res_low  = (paddr == `ADCC_OFF_RES_LOW);
  assign hit_ctrl     = (paddr == `ADCC_OFF_CTRL_PRIMARY);
  assign hit_cfg      = (paddr == `ADCC_OFF_CFG_SECOND);
  assign hit_stat     = (paddr == `ADCC_OFF_IRQ_STATUS);
  assign hit_mask     = (paddr == `ADCC_OFF_IRQ_MASK);
  assign mapped       = hit_res_high || hit_res_low || hit_ctrl || hit_cfg || hit_stat || hit_mask; // [RULE3]

  // Read views; bit 1 and config bits 5-4 are hard zero
  assign ctrl_view = {clk_sel_low_q, chan_sel_q, go_q, 1'b0, converter_power_q}; // [RULE4] [RULE8] [RULE11]
  assign cfg_view  = {justify_q, clk_sel_bit2_q, 2'b00, port_config_q}; // [RULE4]

  // Justification is applied at read time so the stored result stays raw
  assign res_high_view = justify_q ? {6'h00, sar_result[9:8]} : sar_result[9:2]; // [RULE14]
  assign res_low_view  = justify_q ? sar_result[7:0] : {sar_result[1:0], 6'h00}; // [RULE14]

  assign rd_mux = hit_res_high ? {24'h000000, res_high_view} :
                  hit_res_low  ? {24'h000000, res_low_view}  :
                  hit_ctrl     ? {24'h000000, ctrl_view}     :
                  hit_cfg      ? {24'h000000, cfg_view}      :
                  hit_stat     ? {31'h00000000, irq_stat_q}  :
                  hit_mask     ? {31'h00000000, irq_mask_q}  : 32'h00000000;

  // Bus answer flops
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= rd_setup;
      pslverr_q <= rd_setup && !mapped;
      prdata_q  <= (rd_setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Start needs the converter already powered and idle
  assign go_write   = wr_en && hit_ctrl && pwdata[`ADCC_CTRL_GO];
  assign start_conv = go_write && converter_power_q && pwdata[`ADCC_CTRL_POWER] && !go_q; // [RULE8] [RULE16]
  assign done_set   = sar_done;
  assign power_off_wr = wr_en && hit_ctrl && !pwdata[`ADCC_CTRL_POWER]; // [RULE10]

  // Power-off write aborts at once, so busy never outlives the trigger bit
  assign sar_abort = power_off_wr || !converter_power_q; // [RULE10]

  // Reset images; fields are cut from them so every width stays exact
  assign ctrl_reset = `ADCC_CTRL_RESET;
  assign cfg_reset  = `ADCC_CFG_RESET;

  // Primary control register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      clk_sel_low_q     <= ctrl_reset[`ADCC_CTRL_CLK_HI:`ADCC_CTRL_CLK_LO]; // [RULE13] [RULE17]
      chan_sel_q        <= ctrl_reset[`ADCC_CTRL_CHAN_HI:`ADCC_CTRL_CHAN_LO]; // [RULE17]
      converter_power_q <= ctrl_reset[`ADCC_CTRL_POWER]; // [RULE13]
      go_q              <= ctrl_reset[`ADCC_CTRL_GO];
    end else begin
      if (wr_en && hit_ctrl) begin
        clk_sel_low_q     <= pwdata[`ADCC_CTRL_CLK_HI:`ADCC_CTRL_CLK_LO]; // [RULE4]
        chan_sel_q        <= pwdata[`ADCC_CTRL_CHAN_HI:`ADCC_CTRL_CHAN_LO]; // [RULE6]
        converter_power_q <= pwdata[`ADCC_CTRL_POWER]; // [RULE10]
      end
      // Power-off or completion clears the trigger; a start outranks neither
      if (sar_done || power_off_wr) begin
        go_q <= 1'b0; // [RULE9] [RULE10]
      end else if (start_conv) begin
        go_q <= 1'b1; // [RULE8]
      end
    end
  end

  // Secondary configuration register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      justify_q      <= cfg_reset[`ADCC_CFG_JUSTIFY]; // [RULE13]
      clk_sel_bit2_q <= cfg_reset[`ADCC_CFG_CLK2];
      port_config_q  <= cfg_reset[`ADCC_CFG_PORT_HI:`ADCC_CFG_PORT_LO];
    end else if (wr_en && hit_cfg) begin
      justify_q      <= pwdata[`ADCC_CFG_JUSTIFY]; // [RULE14]
      clk_sel_bit2_q <= pwdata[`ADCC_CFG_CLK2]; // [RULE4]
      port_config_q  <= pwdata[`ADCC_CFG_PORT_HI:`ADCC_CFG_PORT_LO];
    end
  end

  // Done flag: a completion in the clearing cycle still sets it
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_stat_q <= 1'b0;
      irq_mask_q <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      if (done_set) begin
        irq_stat_q <= 1'b1; // [RULE12]
      end else if (wr_en && hit_stat && pwdata[`ADCC_IRQ_DONE]) begin
        irq_stat_q <= 1'b0;
      end
      if (wr_en && hit_mask) begin
        irq_mask_q <= pwdata[0:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Channel one-hot limited to inputs this variant really has
  assign chan_enable_d = (converter_power_q && (int'(chan_sel_q) < CHAN_COUNT))
                         ? (8'h01 << chan_sel_q) : 8'h00; // [RULE2] [RULE6] [RULE7]

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      chan_enable_q <= 8'h00;
    end else begin
      chan_enable_q <= chan_enable_d;
    end
  end

  assign clk_sel_full = {clk_sel_bit2_q, clk_sel_low_q}; // [RULE4]

  adcc_tad_div u_div (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .run      (converter_power_q),
    .clk_sel  (clk_sel_full),
    .rc_tick  (rc_tick),
    .tad_en_q (tad_en)
  );

  // Power-down aborts the sequencer so it draws nothing while off
  adcc_sar u_sar (
    .sys_clk       (sys_clk),
    .resetn        (resetn),
    .start         (start_conv),
    .abort         (sar_abort),
    .tad_en        (tad_en),
    .comp_in       (comp_in),
    .busy_q        (sar_busy),
    .done_q        (sar_done),
    .sample_hold_q (sample_hold_q),
    .dac_code_q    (dac_code_q),
    .result_q      (sar_result)
  );

  // Trigger bit tracks the sequencer while the converter is powered
  chk_go_needs_power: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE16]
    !converter_power_q |-> !go_q)
    else $error("trigger set while unpowered");

  chk_start_sets_go: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE8]
    start_conv |=> go_q ##1 sar_busy)
    else $error("start did not raise trigger and busy");

  chk_done_clears_go: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE9]
    sar_done |=> !go_q)
    else $error("trigger not cleared on completion");

  chk_done_sets_flag: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE12]
    sar_done |=> irq_stat_q[0] ##1 (irq_q == irq_mask_q[0]))
    else $error("completion did not set done flag");

  chk_bit1_zero: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE11]
    (rd_setup && !pwrite && hit_ctrl) |=> (prdata_q[1] == 1'b0) && (prdata_q[2] == $past(go_q)))
    else $error("control read view wrong");

  chk_right_justify: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE14]
    (rd_setup && !pwrite && hit_res_high && justify_q) |=> (prdata_q[7:2] == 6'h00))
    else $error("right-justified high byte not zero-padded");

  chk_reset_clears: assert property (@(posedge sys_clk) // [RULE13]
    !resetn |=> (ctrl_view == 8'h00) && !sar_busy && !irq_q)
    else $error("reset did not clear converter");

  chk_busy_matches: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE8]
    sar_busy |-> go_q)
    else $error("conversion busy without trigger bit");

  // Bus answer: one-cycle ready, data zero outside it
  chk_pready_pulse: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE3]
    pready_q |=> !pready_q)
    else $error("ready held longer than one cycle");

  chk_prdata_idle: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE3]
    !pready_q |-> (prdata_q == 32'h00000000))
    else $error("read data shown outside an answer");

  chk_upper_zero: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE3]
    pready_q |-> (prdata_q[31:8] == 24'h000000))
    else $error("read data above the register byte not zero");

  chk_unmapped_error: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE3]
    (rd_setup && !mapped) |=> (pready_q && pslverr_q))
    else $error("unmapped access answered without error");

  chk_mapped_clean: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE3]
    (rd_setup && mapped) |=> (pready_q && !pslverr_q))
    else $error("mapped access answered with error");

  // Read views of control, configuration and result
  chk_power_read: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE10]
    (rd_setup && !pwrite && hit_ctrl) |=> (prdata_q[0] == $past(converter_power_q)))
    else $error("power bit read back wrong");

  chk_chan_read: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE6]
    (rd_setup && !pwrite && hit_ctrl) |=> (prdata_q[5:3] == $past(chan_sel_q)))
    else $error("channel field read back wrong");

  chk_cfg_gap_zero: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE4]
    (rd_setup && !pwrite && hit_cfg) |=> (prdata_q[5:4] == 2'b00))
    else $error("unused configuration bits not zero");

  chk_left_justify: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE14]
    (rd_setup && !pwrite && hit_res_low && !justify_q) |=> (prdata_q[5:0] == 6'h00))
    else $error("left-justified low byte not zero-padded");

  chk_high_left: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE14]
    (rd_setup && !pwrite && hit_res_high && !justify_q) |=> (prdata_q[7:0] == $past(sar_result[9:2])))
    else $error("left-justified high byte wrong");

  // Start, power and channel selection
  chk_go_unpowered: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE16]
    (go_write && !converter_power_q) |=> (!go_q && !sar_busy))
    else $error("trigger write started an unpowered converter");

  chk_go_while_busy: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE8]
    (go_write && go_q && pwdata[`ADCC_CTRL_POWER] && !sar_done) |=> go_q)
    else $error("trigger dropped by a write during conversion");

  chk_hold_while_busy: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE8]
    sar_busy |-> sample_hold_q)
    else $error("conversion running without hold");

  chk_power_off_abort: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE10]
    power_off_wr |=> (!go_q && !sar_busy && !sample_hold_q))
    else $error("power-off did not abort conversion");

  chk_unpowered_idle: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE10]
    !converter_power_q |-> (!sar_busy && !sample_hold_q))
    else $error("sequencer active while unpowered");

  chk_tick_needs_power: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE10]
    !converter_power_q |=> !tad_en)
    else $error("bit tick while unpowered");

  chk_chan_select: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE6]
    (converter_power_q && (int'(chan_sel_q) < CHAN_COUNT)) |=> (chan_enable_q == (8'h01 << $past(chan_sel_q))))
    else $error("channel mux select wrong");

  chk_chan_limit: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE2]
    (!converter_power_q || (int'(chan_sel_q) >= CHAN_COUNT)) |=> (chan_enable_q == 8'h00))
    else $error("absent or unpowered channel enabled");

  // Completion and interrupt
  chk_done_drops_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE12]
    sar_done |-> (!sample_hold_q && !sar_busy))
    else $error("hold still high at completion");

  chk_stat_clear: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE12]
    (wr_en && hit_stat && pwdata[`ADCC_IRQ_DONE] && !done_set) |=> !irq_stat_q[0])
    else $error("done flag not cleared by write of one");

  chk_irq_level: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE12]
    irq_q == $past(irq_stat_q[0] && irq_mask_q[0]))
    else $error("interrupt level does not follow flag and mask");

endmodule

//--- testbench/adcc_top_tb.sv
`timescale 1ns/10ps
`include "adcc_defines.svh"

module adcc_top_tb;
  localparam logic [7:0] HIGH = `ADCC_OFF_RES_HIGH;
  localparam logic [7:0] LOW  = `ADCC_OFF_RES_LOW;
  localparam logic [7:0] CTL  = `ADCC_OFF_CTRL_PRIMARY;
  localparam logic [7:0] CFG  = `ADCC_OFF_CFG_SECOND;
  localparam logic [7:0] STAT = `ADCC_OFF_IRQ_STATUS;
  localparam logic [7:0] MASK = `ADCC_OFF_IRQ_MASK;
  localparam int         DIVS [8] = '{2, 8, 32, 5, 4, 16, 64, 5};
  localparam logic [9:0] VALS [8] = '{10'h3FF, 10'h000, 10'h2A5, 10'h15A, 10'h201, 10'h1FE, 10'h0C3, 10'h33C};

  logic        sys_clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        comp_in = 1'b0;
  logic        rc_tick = 1'b0;
  logic [9:0]  dac_code_q;
  logic        sample_hold_q;
  logic [7:0]  chan_enable_q;
  logic        converter_power_q;
  logic [3:0]  port_config_q;
  logic        irq_q;
  logic [9:0]  analog;
  logic [2:0]  rc_div = 3'h0;
  int          hold_cnt = 0;
  int          error_cnt;
  int          checks;
  logic [31:0] rdat;
  logic        rerr;

  adcc_top i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .comp_in(comp_in), .rc_tick(rc_tick), .dac_code_q(dac_code_q), .sample_hold_q(sample_hold_q),
    .chan_enable_q(chan_enable_q), .converter_power_q(converter_power_q),
    .port_config_q(port_config_q), .irq_q(irq_q)
  );

  // 125 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // RC oscillator stand-in, comparator model and hold-time counter
  always @(posedge sys_clk) begin
    rc_div  <= (rc_div == 3'h4) ? 3'h0 : rc_div + 3'h1;
    rc_tick <= (rc_div == 3'h4);
    comp_in <= (dac_code_q <= analog); // Lags the trial code by a cycle, so ticks must be two apart
    if (sample_hold_q === 1'b1) begin
      hold_cnt <= hold_cnt + 1;
    end
  end

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; the slave's latency is never assumed, only bounded
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready_q !== 1'b1 && n < 20);
    rdat = prdata_q;
    rerr = pslverr_q;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, rdat, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Full conversion on channel 2 with a given clock select and justification
  task automatic convert(input logic [2:0] sel, input logic just, input logic [9:0] val, input int div);
    int h0;
    int k;
    int h;
    analog = val;
    wr(CFG, {24'h0, just, sel[2], 6'h3F});
    rd(CFG, {24'h0, just, sel[2], 6'h0F}, "config");
    chk("port config", {28'h0, port_config_q}, 32'hF);
    wr(CTL, {24'h0, sel[1:0], 3'h2, 3'b001});
    h0 = hold_cnt;
    wr(CTL, {24'h0, sel[1:0], 3'h2, 3'b101});
    rd(CTL, {24'h0, sel[1:0], 3'h2, 3'b101}, "busy");
    k = 0;
    while (rdat[2] === 1'b1 && k < 400) begin
      apb(1'b0, CTL, 32'h0);
      k++;
    end
    if (k >= 400) begin
      error_cnt++;
      report_and_stop();
    end
    h = hold_cnt - h0;
    chk("go cleared", rdat, {24'h0, sel[1:0], 3'h2, 3'b001});
    chk("hold length", 32'(h >= 10 * div && h <= 11 * div + 4), 32'h1);
    chk("dac code", {22'h0, dac_code_q}, {22'h0, val});
    rd(STAT, 32'h1, "done flag");
    rd(HIGH, just ? {30'h0, val[9:8]} : {24'h0, val[9:2]}, "result high");
    rd(LOW, just ? {24'h0, val[7:0]} : {24'h0, val[1:0], 6'h0}, "result low");
    // Quiet gap before the next acquisition may begin
    repeat (2 * div) @(posedge sys_clk);
  endtask

  // Main sequence
  initial begin
    resetn    = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    analog    = 10'h000;
    error_cnt = 0;
    checks    = 0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      rd(8'(4 * a), 32'h0, "reset value");
    end
    rd(8'h18, 32'h0, "unmapped read");
    chk("unmapped error", {31'h0, rerr}, 32'h1);
    wr(CTL, 32'hFE);
    rd(CTL, 32'hF8, "unpowered trigger");
    chk("mux off", {24'h0, chan_enable_q}, 32'h0);
    // Every channel code, with the unimplemented bit written high; all exist on this variant
    for (int c = 0; c < 8; c++) begin
      wr(CTL, {24'h0, 2'b00, 3'(c), 3'b011});
      rd(CTL, {24'h0, 2'b00, 3'(c), 3'b001}, "bit one");
      chk("channel", {24'h0, chan_enable_q}, 32'h1 << c);
    end
    // Every clock select; interrupt unmasked for the first half only
    for (int i = 0; i < 8; i++) begin
      wr(MASK, {31'h0, i < 4});
      convert(3'(i), i[0], VALS[i], DIVS[i]);
      chk("irq level", {31'h0, irq_q}, {31'h0, i < 4});
      wr(STAT, 32'h1);
      rd(STAT, 32'h0, "flag cleared");
      chk("irq cleared", {31'h0, irq_q}, 32'h0);
    end
    // Power-off in mid-conversion aborts it and keeps the old result
    analog = 10'h111;
    wr(CTL, 32'hC1);
    wr(CTL, 32'hC5);
    repeat (20) @(posedge sys_clk);
    wr(CTL, 32'hC0);
    rd(CTL, 32'hC0, "abort");
    chk("abort pins", {30'h0, converter_power_q, sample_hold_q}, 32'h0);
    rd(STAT, 32'h0, "abort flag");
    rd(LOW, {24'h0, VALS[7][7:0]}, "result kept");
    // Reset in mid-conversion
    wr(CTL, 32'hC1);
    wr(CTL, 32'hC5);
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      rd(8'(4 * a), 32'h0, "second reset");
    end
    chk("reset hold", {31'h0, sample_hold_q}, 32'h0);
    report_and_stop();
  end
endmodule
